// ==== common/wdg_pkg.sv ====
package wdg_pkg;
    // register byte offsets on the bus
    localparam logic [11:0] ADR_LOAD = 12'h000;
    localparam logic [11:0] ADR_VALUE = 12'h004;
    localparam logic [11:0] ADR_CTL = 12'h008;
    localparam logic [11:0] ADR_ICR = 12'h00C;
    localparam logic [11:0] ADR_RIS = 12'h010;
    localparam logic [11:0] ADR_MIS = 12'h014;
    localparam logic [11:0] ADR_EVT = 12'h018;
    localparam logic [11:0] ADR_MASK = 12'h01C;
    localparam logic [11:0] ADR_TEST = 12'h418;
    localparam logic [11:0] ADR_LOCK = 12'hC00;

    // control and test field positions
    localparam int CTL_TIMEOUT_INTERRUPT_ENABLE_BIT = 0;
    localparam int CTL_RESET_OUTPUT_ENABLE_BIT = 1;
    localparam int TEST_STALL_BIT = 8;

    // event status and mask field positions
    localparam int EVT_TIMEOUT_BIT = 0;
    localparam int EVT_BITE_BIT = 1;
    localparam int EVT_W = 2;

    // reset values and the unlock key
    localparam logic [31:0] LOAD_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] VALUE_RST = 32'hFFFF_FFFF;
    localparam logic [1:0] EVT_MASK_RST = 2'h0;
    localparam logic [31:0] UNLOCK_KEY = 32'h1ACC_E551;

    // interrupt stage, gray coded along clear -> pending -> bite
    typedef enum logic [1:0] {
        ST_CLEAR = 2'b00,
        ST_PEND = 2'b01,
        ST_BITE = 2'b11
    } wdg_stage_e;
endpackage

// ==== core/wdg_wb_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdg_wb_slave (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave side
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // request toward the register file
    output logic req_wr_o,
    output logic req_rd_o,
    input wire logic [31:0] rdata_i
);
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wdg_slv_s;

    wdg_slv_s s_reg;
    wdg_slv_s s_next;
    logic active;

    ////////////////////////////////////////////////////////////////////////
    // one access per request, ack in the cycle after it is taken
    assign active = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign req_wr_o = active & wb_we_i;
    assign req_rd_o = active & ~wb_we_i;

    // next state: ack pulse and captured read data
    always_comb begin
        s_next = s_reg;
        s_next.ack = active;
        if (req_rd_o) begin
            s_next.dat = rdata_i;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.dat;
endmodule
`default_nettype wire

// ==== core/wdg_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdg_core (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // system side
    input wire logic timeout_clock_gate_bit_i,
    input wire logic dbg_halt_i,
    output logic irq_o,
    output logic sys_rst_o
);
    typedef struct packed {
        logic [31:0] load;
        logic [31:0] cnt;
        logic timeout_interrupt_enable;
        logic reset_output_enable;
        logic stall_en;
        logic locked;
        wdg_pkg::wdg_stage_e stage;
        logic [1:0] evt;
        logic [1:0] evt_mask;
        logic irq;
        logic bite;
    } wdg_core_s;

    wdg_core_s s_reg;
    wdg_core_s s_next;
    logic req_wr;
    logic req_rd;
    logic [31:0] rdata;
    logic [31:0] wmask;
    logic [31:0] load_wr;
    logic wr_ok;
    logic wr_lock;
    logic running;
    logic expire;
    logic rd_clr;
    logic [1:0] evt_set;

    ////////////////////////////////////////////////////////////////////////
    // bus slave
    wdg_wb_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .req_wr_o(req_wr),
        .req_rd_o(req_rd),
        .rdata_i(rdata)
    );

    // byte lane mask from the select lines
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wmask[8*i +: 8] = {8{wb_sel_i[i]}};
    end
    assign load_wr = (s_reg.load & ~wmask) | (wb_dat_i & wmask);

    // write qualifiers: gate off blocks all, lock blocks all but lock itself
    assign wr_lock = req_wr & timeout_clock_gate_bit_i;
    assign wr_ok = wr_lock & ~s_reg.locked;

    // counter runs when enabled, clocked and not stalled by debug
    assign running = s_reg.timeout_interrupt_enable & timeout_clock_gate_bit_i
        & ~(s_reg.stall_en & dbg_halt_i);
    assign expire = running & (s_reg.cnt == 32'h0000_0000);
    assign rd_clr = req_rd & timeout_clock_gate_bit_i & (wb_adr_i == wdg_pkg::ADR_EVT);

    ////////////////////////////////////////////////////////////////////////
    // read data mux, reserved bits read zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (timeout_clock_gate_bit_i) begin
            case (wb_adr_i)
                wdg_pkg::ADR_LOAD: rdata = s_reg.load;
                wdg_pkg::ADR_VALUE: rdata = s_reg.cnt;
                wdg_pkg::ADR_CTL: begin
                    rdata[wdg_pkg::CTL_TIMEOUT_INTERRUPT_ENABLE_BIT] = s_reg.timeout_interrupt_enable;
                    rdata[wdg_pkg::CTL_RESET_OUTPUT_ENABLE_BIT] = s_reg.reset_output_enable;
                end
                wdg_pkg::ADR_RIS: rdata[0] = (s_reg.stage != wdg_pkg::ST_CLEAR);
                wdg_pkg::ADR_MIS: begin
                    rdata[0] = (s_reg.stage != wdg_pkg::ST_CLEAR)
                        & s_reg.evt_mask[wdg_pkg::EVT_TIMEOUT_BIT];
                end
                wdg_pkg::ADR_EVT: rdata[1:0] = s_reg.evt;
                wdg_pkg::ADR_MASK: rdata[1:0] = s_reg.evt_mask;
                wdg_pkg::ADR_TEST: rdata[wdg_pkg::TEST_STALL_BIT] = s_reg.stall_en;
                wdg_pkg::ADR_LOCK: rdata[0] = s_reg.locked;
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_next = s_reg;
        evt_set = 2'b00;
        // count down while running
        if (running && !expire) begin
            s_next.cnt = s_reg.cnt - 32'h0000_0001;
        end
        // time-out: first raises interrupt, second bites only when reset output is enabled
        if (expire) begin
            s_next.cnt = s_reg.load;
            case (s_reg.stage)
                wdg_pkg::ST_CLEAR: begin
                    s_next.stage = wdg_pkg::ST_PEND;
                    evt_set[wdg_pkg::EVT_TIMEOUT_BIT] = 1'b1;
                end
                wdg_pkg::ST_PEND: begin
                    if (s_reg.reset_output_enable) begin
                        s_next.stage = wdg_pkg::ST_BITE;
                        s_next.bite = 1'b1;
                        evt_set[wdg_pkg::EVT_BITE_BIT] = 1'b1;
                    end
                end
                default: s_next.stage = s_reg.stage;
            endcase
        end
        // register writes
        if (wr_ok) begin
            case (wb_adr_i)
                wdg_pkg::ADR_LOAD: begin
                    s_next.load = load_wr;
                    s_next.cnt = load_wr;
                    if (load_wr == 32'h0000_0000 && s_reg.stage == wdg_pkg::ST_CLEAR) begin
                        s_next.stage = wdg_pkg::ST_PEND;
                        evt_set[wdg_pkg::EVT_TIMEOUT_BIT] = 1'b1;
                    end
                end
                wdg_pkg::ADR_CTL: begin
                    if (!s_reg.timeout_interrupt_enable && wb_sel_i[0]) begin
                        s_next.reset_output_enable = wb_dat_i[wdg_pkg::CTL_RESET_OUTPUT_ENABLE_BIT];
                        s_next.timeout_interrupt_enable = wb_dat_i[wdg_pkg::CTL_TIMEOUT_INTERRUPT_ENABLE_BIT];
                        if (wb_dat_i[wdg_pkg::CTL_TIMEOUT_INTERRUPT_ENABLE_BIT]) begin
                            s_next.cnt = s_reg.load;
                        end
                    end
                end
                wdg_pkg::ADR_ICR: begin
                    s_next.cnt = s_reg.load;
                    if (s_reg.stage == wdg_pkg::ST_PEND && !expire) begin
                        s_next.stage = wdg_pkg::ST_CLEAR;
                    end
                end
                wdg_pkg::ADR_TEST: begin
                    if (wb_sel_i[1]) begin
                        s_next.stall_en = wb_dat_i[wdg_pkg::TEST_STALL_BIT];
                    end
                end
                wdg_pkg::ADR_MASK: begin
                    if (wb_sel_i[0]) begin
                        s_next.evt_mask = wb_dat_i[1:0];
                    end
                end
                default: s_next.load = s_next.load;
            endcase
        end
        // lock register stays writable while locked
        if (wr_lock && wb_adr_i == wdg_pkg::ADR_LOCK) begin
            s_next.locked = (wb_dat_i != wdg_pkg::UNLOCK_KEY);
        end
        // sticky events, read clears, a new event wins
        s_next.evt = (s_reg.evt & ~{2{rd_clr}}) | evt_set;
        s_next.irq = |(s_next.evt & s_next.evt_mask);
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg.load <= wdg_pkg::LOAD_RST;
            s_reg.cnt <= wdg_pkg::VALUE_RST;
            s_reg.timeout_interrupt_enable <= 1'b0;
            s_reg.reset_output_enable <= 1'b0;
            s_reg.stall_en <= 1'b0;
            s_reg.locked <= 1'b0;
            s_reg.stage <= wdg_pkg::ST_CLEAR;
            s_reg.evt <= 2'b00;
            s_reg.evt_mask <= wdg_pkg::EVT_MASK_RST;
            s_reg.irq <= 1'b0;
            s_reg.bite <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign irq_o = s_reg.irq;
    assign sys_rst_o = s_reg.bite;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_expire_clear;
        expire && s_reg.stage == wdg_pkg::ST_CLEAR && !wr_ok;
    endsequence

    sequence s_expire_pend;
        expire && s_reg.stage == wdg_pkg::ST_PEND && !wr_ok;
    endsequence

    sequence s_quiet;
        !wr_ok;
    endsequence

    a_count_down: assert property (
        running && !expire && !wr_ok |=> s_reg.cnt == $past(s_reg.cnt) - 32'h0000_0001)
        else $error("counter did not step down by one");

    a_first_timeout: assert property (
        s_expire_clear |=> s_reg.stage == wdg_pkg::ST_PEND && s_reg.cnt == $past(s_reg.load))
        else $error("first time-out did not pend and reload");

    a_second_bite: assert property (
        s_expire_pend ##0 s_reg.reset_output_enable |=> sys_rst_o ##1 sys_rst_o)
        else $error("second time-out did not assert reset");

    a_no_bite_off: assert property (
        s_expire_pend ##0 !s_reg.reset_output_enable && !sys_rst_o |=> !sys_rst_o)
        else $error("reset asserted while disabled");

    a_clear_reload: assert property (
        wr_ok && wb_adr_i == wdg_pkg::ADR_ICR && !expire
        |=> s_reg.stage != wdg_pkg::ST_PEND && s_reg.cnt == $past(s_reg.load))
        else $error("clear write did not clear and reload");

    a_load_write: assert property (
        wr_ok && wb_adr_i == wdg_pkg::ADR_LOAD && wb_sel_i == 4'hF |=> s_reg.cnt == $past(wb_dat_i))
        else $error("load write did not reach the counter");

    a_load_keeps_irq: assert property (
        wr_ok && wb_adr_i == wdg_pkg::ADR_LOAD && s_reg.stage != wdg_pkg::ST_CLEAR
        |=> s_reg.stage != wdg_pkg::ST_CLEAR)
        else $error("load write cleared the interrupt");

    a_enable_preload: assert property (
        wr_ok && wb_adr_i == wdg_pkg::ADR_CTL && !s_reg.timeout_interrupt_enable && wb_sel_i[0] && wb_dat_i[0]
        |=> s_reg.timeout_interrupt_enable && s_reg.cnt == $past(s_reg.load))
        else $error("enable did not preload the counter");

    a_gate_freeze: assert property (
        !timeout_clock_gate_bit_i |=> $stable(s_reg.cnt) && $stable(s_reg.load))
        else $error("block moved with clock gate off");

    a_stall_freeze: assert property (
        s_reg.stall_en && dbg_halt_i ##0 s_quiet |=> $stable(s_reg.cnt))
        else $error("counter moved during debug halt");

    a_mask_gate: assert property (
        s_reg.evt_mask == 2'b00 |-> !irq_o ##1 (s_reg.evt_mask != 2'b00 || !irq_o))
        else $error("masked event reached the interrupt");

    a_lock_blocks: assert property (
        s_reg.locked && req_wr && wb_adr_i != wdg_pkg::ADR_LOCK
        |=> $stable(s_reg.load) && ($past(running) || $stable(s_reg.cnt)))
        else $error("write took effect while locked");

    a_ctl_frozen: assert property (
        s_reg.timeout_interrupt_enable |=> s_reg.timeout_interrupt_enable && $stable(s_reg.reset_output_enable))
        else $error("control changed after enable");

    a_zero_load: assert property (
        wr_ok && wb_adr_i == wdg_pkg::ADR_LOAD && load_wr == 32'h0000_0000
        |=> s_reg.stage != wdg_pkg::ST_CLEAR)
        else $error("zero load raised no interrupt");

    a_bite_holds: assert property (
        sys_rst_o |=> sys_rst_o [*3])
        else $error("reset output dropped before reset");
endmodule
`default_nettype wire

// ==== tb/wdg_sys_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdg_sys_model #(
    parameter int HOLD = 4
) (
    // clock
    input wire logic clk_i,
    // watchdog outputs
    input wire logic irq_i,
    input wire logic sys_rst_i,
    // reset fed back to the block, interrupt count
    output logic rst_req_o,
    output logic [7:0] irq_cnt_o
);
    int wait_cnt = 0;
    logic irq_q = 1'b0;
    initial rst_req_o = 1'b0;
    initial irq_cnt_o = 8'h00;
    ////////////////////////////////////////////////////////////////
    // reset controller: holds off a few cycles, then resets until the request drops
    always @(posedge clk_i) begin
        if (sys_rst_i === 1'b1) begin
            if (wait_cnt >= HOLD) rst_req_o <= 1'b1;
            else wait_cnt <= wait_cnt + 1;
        end else begin
            wait_cnt <= 0;
            rst_req_o <= 1'b0;
        end
    end
    // processor side counts interrupt entries
    always @(posedge clk_i) begin
        irq_q <= irq_i;
        if (irq_i === 1'b1 && irq_q === 1'b0) irq_cnt_o <= irq_cnt_o + 8'h01;
    end
endmodule
`default_nettype wire

// ==== tb/tb_watchdog_two_stage_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_two_stage_timer;
    logic clk_i = 1'b0;
    logic rst_tb = 1'b1;
    logic rst_i;
    logic rst_req;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [31:0] dat_r;
    logic ack;
    logic gate = 1'b0;
    logic halt = 1'b0;
    logic irq;
    logic sys_rst;
    logic [7:0] irq_cnt;
    logic [31:0] rng = 32'h5cb1_0e49;
    logic [31:0] rnd_load;
    logic [31:0] exp_q[$];
    string name_q[$];
    int errors = 0;
    int cmp_count = 0;

    assign rst_i = rst_tb | rst_req;
    always #5 clk_i = ~clk_i;

    wdg_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .timeout_clock_gate_bit_i(gate), .dbg_halt_i(halt), .irq_o(irq),
        .sys_rst_o(sys_rst));
    wdg_sys_model #(.HOLD(4)) model (.clk_i(clk_i), .irq_i(irq), .sys_rst_i(sys_rst),
        .rst_req_o(rst_req), .irq_cnt_o(irq_cnt));

    ////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) check("ack", 1'b0, 1'b1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
        exp_q.push_back(e);
        name_q.push_back(what);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wait_out(input bit for_rst, input int limit);
        int n;
        n = 0;
        while (((for_rst ? sys_rst : irq) !== 1'b1) && n < limit) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // read monitor: oldest note against the data acked on a read
    always @(posedge clk_i) begin
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) check("unexpected read", 32'h0000_0001, 32'h0000_0000);
            else check(name_q.pop_front(), dat_r, exp_q.pop_front());
        end
    end
    // hang guard
    initial begin
        #50000;
        errors++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        test_done();
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_tb <= 1'b0;
        wr(wdg_pkg::ADR_LOAD, 32'h0000_0005);
        rd(wdg_pkg::ADR_LOAD, 32'h0000_0000, "load gated");
        @(posedge clk_i) gate <= 1'b1;
        rd(wdg_pkg::ADR_LOAD, wdg_pkg::LOAD_RST, "load");
        rd(wdg_pkg::ADR_VALUE, wdg_pkg::VALUE_RST, "value");
        rd(wdg_pkg::ADR_CTL, 32'h0000_0000, "ctl");
        rd(wdg_pkg::ADR_RIS, 32'h0000_0000, "ris");
        rd(12'h100, 32'h0000_0000, "unmapped");
        // stalled start, preload and immediate load
        wr(wdg_pkg::ADR_MASK, 32'h0000_0003);
        wr(wdg_pkg::ADR_TEST, 32'h0000_0100);
        @(posedge clk_i) halt <= 1'b1;
        wr(wdg_pkg::ADR_LOAD, 32'h0000_0028);
        wr(wdg_pkg::ADR_CTL, 32'h0000_0002);
        rd(wdg_pkg::ADR_CTL, 32'h0000_0002, "ctl reset_output_enable");
        wr(wdg_pkg::ADR_CTL, 32'h0000_0003);
        repeat (5) @(posedge clk_i);
        rd(wdg_pkg::ADR_VALUE, 32'h0000_0028, "value halted");
        wr(wdg_pkg::ADR_LOAD, 32'h0000_0019);
        rd(wdg_pkg::ADR_VALUE, 32'h0000_0019, "value reload");
        wr(wdg_pkg::ADR_CTL, 32'h0000_0000);
        rd(wdg_pkg::ADR_CTL, 32'h0000_0003, "ctl locked");
        @(posedge clk_i) halt <= 1'b0;
        // first time-out, clear
        wait_out(1'b0, 200);
        check("irq first", irq, 1'b1);
        rd(wdg_pkg::ADR_RIS, 32'h0000_0001, "ris set");
        rd(wdg_pkg::ADR_MIS, 32'h0000_0001, "mis set");
        rng = xorshift(rng);
        rnd_load = 32'h0000_0064 + {26'h0, rng[5:0]};
        wr(wdg_pkg::ADR_LOAD, rnd_load);
        rd(wdg_pkg::ADR_RIS, 32'h0000_0001, "ris after load");
        wr(wdg_pkg::ADR_ICR, rng);
        rd(wdg_pkg::ADR_RIS, 32'h0000_0000, "ris cleared");
        rd(wdg_pkg::ADR_EVT, 32'h0000_0001, "evt");
        repeat (2) @(posedge clk_i);
        check("irq after evt read", irq, 1'b0);
        // lock and unlock
        rng = xorshift(rng);
        wr(wdg_pkg::ADR_LOCK, {rng[31:1], 1'b0});
        rd(wdg_pkg::ADR_LOCK, 32'h0000_0001, "locked");
        wr(wdg_pkg::ADR_LOAD, 32'h0000_0007);
        rd(wdg_pkg::ADR_LOAD, rnd_load, "load locked");
        wr(wdg_pkg::ADR_LOCK, wdg_pkg::UNLOCK_KEY);
        rd(wdg_pkg::ADR_LOCK, 32'h0000_0000, "unlocked");
        // second time-out without clear
        wr(wdg_pkg::ADR_LOAD, 32'h0000_001E);
        wait_out(1'b1, 200);
        check("sys rst", sys_rst, 1'b1);
        check("irq pending", irq, 1'b1);
        repeat (3) @(posedge clk_i);
        check("sys rst held", sys_rst, 1'b1);
        repeat (10) @(posedge clk_i);
        check("sys rst released", sys_rst, 1'b0);
        rd(wdg_pkg::ADR_CTL, 32'h0000_0000, "ctl after reset");
        // zero load, masked
        wr(wdg_pkg::ADR_MASK, 32'h0000_0000);
        wr(wdg_pkg::ADR_LOAD, 32'h0000_0000);
        rd(wdg_pkg::ADR_RIS, 32'h0000_0001, "ris zero load");
        rd(wdg_pkg::ADR_MIS, 32'h0000_0000, "mis masked");
        check("irq masked", irq, 1'b0);
        check("irq count", irq_cnt, 8'h02);
        // let the monitor take the last read before closing
        repeat (2) @(posedge clk_i);
        check("reads pending", exp_q.size(), 32'h0000_0000);
        test_done();
    end
endmodule
`default_nettype wire
